// file: dac_cmd_pkg.sv
// Package: constants, types and encodings for the quad DAC I2C command port.
// Assumes: single 10 MHz clock domain; pins synchronised inside the top module.
package dac_cmd_pkg;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam logic [4:0] ADDR_FIXED = 5'h03;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD_DAC = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PWRDN = 4'h4;
  localparam logic [3:0] CMD_MASK = 4'h5;
  localparam int CMD_MSB = 23;
  localparam int SEL_MSB = 19;
  localparam int PD_W = 2;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] PD_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] BYTE_LAST = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WDAT = 3'b011,
    ST_WACK = 3'b100,
    ST_RDAT = 3'b101,
    ST_RACK = 3'b110
  } i2c_state_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] sel;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_pins_t;
endpackage : dac_cmd_pkg

// file: quad_dac_i2c_command_port.sv
// Quad DAC I2C slave command port: frame decode, input/DAC registers, power-down modes.
// Assumes: scl, sda and load_update_n are asynchronous pins; sda is open drain outside.
`timescale 1ns/100ps
`default_nettype none

module quad_dac_i2c_command_port
  import dac_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap and load pins
  input wire logic addr_sel_hi_pin,
  input wire logic addr_sel_lo_pin,
  input wire logic load_update_n,
  // Channel outputs, A in the lowest slice
  output logic [NUM_CH*DATA_W-1:0] dac_code,
  output logic [NUM_CH*PD_W-1:0] pwrdn_mode,
  output logic [NUM_CH-1:0] load_mask
);

  function automatic logic [1:0] first_ch(input logic [3:0] sel);
    logic [1:0] r;
    r = 2'h0;
    if (sel[0]) r = 2'h0;
    else if (sel[1]) r = 2'h1;
    else if (sel[2]) r = 2'h2;
    else if (sel[3]) r = 2'h3;
    return r;
  endfunction

  // Pin synchronisers
  logic [1:0] scl_s_q, sda_s_q, ld_s_q, ahi_s_q, alo_s_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      ld_s_q <= 2'h3;
      ahi_s_q <= 2'h0;
      alo_s_q <= 2'h0;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      ld_s_q <= {ld_s_q[0], load_update_n};
      ahi_s_q <= {ahi_s_q[0], addr_sel_hi_pin};
      alo_s_q <= {alo_s_q[0], addr_sel_lo_pin};
    end
  end

  logic scl_q, sda_q, ld_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ld_q <= 1'b1;
    end else if (clk_en) begin
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
      ld_q <= ld_s_q[1];
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, ld_fall, ld_low;
  assign scl_rise = scl_s_q[1] & ~scl_q;
  assign scl_fall = ~scl_s_q[1] & scl_q;
  assign start_det = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  assign stop_det = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
  assign ld_fall = ld_q & ~ld_s_q[1];
  assign ld_low = ~ld_s_q[1];

  logic [6:0] my_addr;
  assign my_addr = {ADDR_FIXED, ahi_s_q[1], alo_s_q[1]};

  // Bus state
  i2c_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] byte_q;
  logic [23:0] frame_q;
  logic rd_q, frame_go;
  logic [1:0] ptr_q;
  logic [15:0] tx_word;
  logic [DATA_W-1:0] in_reg_q [NUM_CH];
  logic [DATA_W-1:0] dac_reg_q [NUM_CH];
  logic [3:0] mask_q;
  logic [7:0] pd_q;
  frame_t frm;

  assign frm = frame_t'(frame_q);
  assign tx_word = in_reg_q[ptr_q];

  // Byte engine; data sampled on SCL rise, SDA driven after SCL fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
    end else if (clk_en) begin
      if (stop_det) begin
        state_q <= ST_IDLE;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
      end else begin
        unique case (state_q)
          ST_IDLE: ;
          ST_ADDR, ST_WDAT: if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == BIT_LAST + 4'h1) begin
            bit_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (sh_q[7:1] == my_addr) begin
                state_q <= ST_AACK;
                rd_q <= sh_q[0];
                byte_q <= 2'h0;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              state_q <= ST_WACK;
            end
          end
          ST_AACK, ST_WACK: if (scl_fall) begin
            state_q <= (state_q == ST_AACK && rd_q) ? ST_RDAT : ST_WDAT;
            if (state_q == ST_WACK) byte_q <= (byte_q == BYTE_LAST) ? 2'h0 : byte_q + 2'h1;
          end
          ST_RDAT: if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == BIT_LAST) begin
              bit_q <= 4'h0;
              state_q <= ST_RACK;
            end
          end else if (scl_rise) begin
          end
          ST_RACK: if (scl_rise) begin
            byte_q <= byte_q ^ 2'h1;
            if (sda_q) state_q <= ST_IDLE;
          end else if (scl_fall) begin
            state_q <= ST_RDAT;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Frame assembly; the command byte also sets the readback pointer
  assign frame_go = clk_en && !stop_det && !start_det && state_q == ST_WACK && scl_fall && byte_q == BYTE_LAST;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= 24'h000000;
    end else if (clk_en && state_q == ST_WDAT && scl_fall && bit_q == BIT_LAST + 4'h1) begin
      frame_q <= {frame_q[15:0], sh_q};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 2'h0;
    end else if (clk_en) begin
      if (state_q == ST_WDAT && scl_fall && bit_q == BIT_LAST + 4'h1 && byte_q == 2'h0) begin
        ptr_q <= first_ch(sh_q[3:0]);
      end else if (state_q == ST_RACK && scl_rise && byte_q[0]) begin
        ptr_q <= ptr_q + 2'h1;
      end
    end
  end

  function automatic int rd_bit(input i2c_state_t st, input logic [3:0] b);
    return (st == ST_RDAT) ? int'(b) + 1 : 0;
  endfunction

  // SDA driver: acknowledge and read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      if (stop_det || start_det) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (state_q == ST_ADDR && bit_q == BIT_LAST + 4'h1) begin
          sda_oe <= (sh_q[7:1] == my_addr);
        end else if (state_q == ST_WDAT && bit_q == BIT_LAST + 4'h1) begin
          sda_oe <= 1'b1;
        end else if ((state_q == ST_AACK && rd_q) || (state_q == ST_RACK) ||
                     (state_q == ST_RDAT && bit_q != BIT_LAST)) begin
          sda_oe <= ~(byte_q[0] ? tx_word[7 - rd_bit(state_q, bit_q)] :
                      tx_word[15 - rd_bit(state_q, bit_q)]);
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (state_q == ST_RACK && scl_rise && !sda_q) begin
        sda_oe <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;

  // Channel registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= MASK_RST;
      pd_q <= PD_RST;
    end else if (frame_go) begin
      if (frm.cmd == CMD_PWRDN) pd_q <= sh_q;
      if (frm.cmd == CMD_MASK) mask_q <= sh_q[3:0];
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic wr_in, upd;
      assign wr_in = frame_go && frm.sel[c] && (frm.cmd == CMD_WR_IN || frm.cmd == CMD_WR_UPD);
      assign upd = frame_go && frm.sel[c] && (frm.cmd == CMD_UPD_DAC);
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          in_reg_q[c] <= DATA_RST;
        end else if (wr_in) begin
          in_reg_q[c] <= frm.data;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          dac_reg_q[c] <= DATA_RST;
        end else if (frame_go && frm.sel[c] && (frm.cmd == CMD_WR_UPD ||
                     (frm.cmd == CMD_WR_IN && ld_low && !mask_q[c]))) begin
          dac_reg_q[c] <= frm.data;
        end else if (upd) begin
          dac_reg_q[c] <= in_reg_q[c];
        end else if (clk_en && ld_fall && !mask_q[c]) begin
          dac_reg_q[c] <= in_reg_q[c];
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          dac_code[c*DATA_W +: DATA_W] <= DATA_RST;
        end else if (clk_en) begin
          dac_code[c*DATA_W +: DATA_W] <= dac_reg_q[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrdn_mode <= PD_RST;
      load_mask <= MASK_RST;
    end else if (clk_en) begin
      pwrdn_mode <= pd_q;
      load_mask <= mask_q;
    end
  end

  // Decoded event used by the a_upd_copy check below
  logic upd_any;
  assign upd_any = frame_go && frm.cmd == CMD_UPD_DAC;

  // Bus event sequences
  sequence s_addr_byte_end;
    clk_en && !start_det && !stop_det && state_q == ST_ADDR && scl_fall && bit_q == BIT_LAST + 4'h1;
  endsequence
  sequence s_cmd_byte_end;
    clk_en && !start_det && !stop_det && state_q == ST_WDAT && scl_fall &&
      bit_q == BIT_LAST + 4'h1 && byte_q == 2'h0;
  endsequence
  sequence s_read_launch;
    clk_en && !start_det && !stop_det && state_q == ST_AACK && rd_q && scl_fall;
  endsequence
  sequence s_stop_seen;
    clk_en && stop_det;
  endsequence
  sequence s_bus_released;
    state_q == ST_IDLE ##1 !sda_oe;
  endsequence

  // Addressing checks
  a_ack_addr: assert property (@(posedge clk) disable iff (!rst_b)
    s_addr_byte_end ##0 (sh_q[7:1] != my_addr) |=> !sda_oe) else $error("ack given to foreign address");
  a_ack_match: assert property (@(posedge clk) disable iff (!rst_b)
    s_addr_byte_end ##0 (sh_q[7:1] == my_addr) |=> sda_oe && state_q == ST_AACK)
    else $error("own address not acknowledged");

  // Register checks
  a_pd_load: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_go && frm.cmd == CMD_PWRDN) |=> pd_q == $past(sh_q)) else $error("power-down not loaded");
  a_pd_out: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en |=> pwrdn_mode == $past(pd_q)) else $error("power-down outputs stale");
  a_write_update: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_go && frm.cmd == CMD_WR_UPD && frm.sel[0]) |=> dac_reg_q[0] == in_reg_q[0])
    else $error("write-update missed DAC");
  a_wr_data: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_go && frm.cmd == CMD_WR_IN && frm.sel[2]) |=> in_reg_q[2] == $past(frm.data))
    else $error("input register not written");
  a_nop_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_go && frm.cmd == CMD_NOP && !ld_fall) |=> $stable(pd_q) && $stable(mask_q))
    else $error("no-op changed state");
  a_upd_copy: assert property (@(posedge clk) disable iff (!rst_b)
    (upd_any) |=> $stable(in_reg_q[0])) else $error("update changed input");
  a_load_fall: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && ld_fall && !mask_q[1] && !frame_go) |=> dac_reg_q[1] == $past(in_reg_q[1]))
    else $error("load edge missed");

  // Readback and stop checks
  a_rd_start: assert property (@(posedge clk) disable iff (!rst_b)
    s_cmd_byte_end ##0 (sh_q[0] == 1'b1) |=> ptr_q == 2'h0) else $error("readback did not start at A");
  a_rd_msb: assert property (@(posedge clk) disable iff (!rst_b)
    s_read_launch |=> sda_oe == !$past(tx_word[15])) else $error("first read bit wrong");
  a_wrap_ptr: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && state_q == ST_RACK && scl_rise && byte_q[0] && ptr_q == 2'h3 && !start_det && !stop_det)
    |=> ptr_q == 2'h0) else $error("readback did not wrap");
  a_stop_idle: assert property (@(posedge clk) disable iff (!rst_b)
    s_stop_seen |=> s_bus_released) else $error("stop not honoured");

endmodule // quad_dac_i2c_command_port
`default_nettype wire

// file: i2c_master_model.sv
// I2C bus master model: drives SCL and pulls SDA low, open drain.
// Assumes: the bench resolves SDA with a pull-up; 10 clk per half() step, three steps per bit.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  // Clock and bus
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // SCL stands high and SDA is released between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic half;
    repeat (10) @(posedge clk);
  endtask
  // Start or repeated start: SDA falls while SCL high
  task automatic start;
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  // One bit: SDA set while SCL low, held through SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
  // Stop: SDA rises while SCL high
  task automatic stop;
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask
endmodule // i2c_master_model
`default_nettype wire

// file: tb.sv
// Testbench: I2C frames, readback, load pin and power-down on the command port.
// Assumes: master model on the far side; SDA pulled up; 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb
  import dac_cmd_pkg::*;
;
  logic clk, rst_b, addr_sel_hi_pin, addr_sel_lo_pin, load_update_n, scl, sda_pull, sda_oe, sda_out, k;
  logic [63:0] dac_code;
  logic [7:0] pwrdn_mode, q;
  logic [3:0] load_mask, mask_m;
  logic [15:0] in_m[4], dac_m[4];
  logic [7:0] pd_m;
  logic [31:0] rnd;
  int errors, samples_checked;
  wire logic sda_line;
  assign sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);
  quad_dac_i2c_command_port quad_dac_i2c_command_port_inst (.clk, .rst_b, .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda_line), .sda_out, .sda_oe, .addr_sel_hi_pin, .addr_sel_lo_pin, .load_update_n, .dac_code,
    .pwrdn_mode, .load_mask);
  i2c_master_model i2c_master_model_inst (.clk, .sda_line, .scl, .sda_pull);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_all;
    chk("dac_code", {dac_m[3], dac_m[2], dac_m[1], dac_m[0]}, dac_code);
    chk("pwrdn_mode", 64'(pd_m), 64'(pwrdn_mode));
    chk("load_mask", 64'(mask_m), 64'(load_mask));
  endtask
  task automatic wbyte(input logic [7:0] b);
    i2c_master_model_inst.xfer(b, 1'b1, q, k);
    chk("ack", 64'h0, 64'(k));
  endtask
  // Expected register state after a frame
  task automatic apply(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    for (int ch = 0; ch < NUM_CH; ch++) if (s[ch]) begin
      if (c == CMD_WR_IN || c == CMD_WR_UPD) in_m[ch] = d;
      if (c == CMD_UPD_DAC || c == CMD_WR_UPD || (c == CMD_WR_IN && !load_update_n && !mask_m[ch]))
        dac_m[ch] = in_m[ch];
    end
    if (c == CMD_PWRDN) pd_m = d[7:0];
    if (c == CMD_MASK) mask_m = d[3:0];
  endtask
  task automatic frame(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    i2c_master_model_inst.start();
    wbyte({ADDR_FIXED, addr_sel_hi_pin, addr_sel_lo_pin, 1'b0});
    wbyte({c, s});
    wbyte(d[15:8]);
    wbyte(d[7:0]);
    i2c_master_model_inst.stop();
    apply(c, s, d);
    check_all();
  endtask
  task automatic readback(input logic [3:0] s, input int n);
    logic [15:0] w;
    int p;
    p = s[0] ? 0 : s[1] ? 1 : s[2] ? 2 : 3;
    i2c_master_model_inst.start();
    wbyte({ADDR_FIXED, addr_sel_hi_pin, addr_sel_lo_pin, 1'b0});
    wbyte({CMD_NOP, s});
    i2c_master_model_inst.start();
    wbyte({ADDR_FIXED, addr_sel_hi_pin, addr_sel_lo_pin, 1'b1});
    for (int i = 0; i < n; i++) begin
      i2c_master_model_inst.xfer(8'hFF, 1'b0, w[15:8], k);
      i2c_master_model_inst.xfer(8'hFF, i == n - 1, w[7:0], k);
      chk("readback", 64'(in_m[p]), 64'(w));
      p = (p + 1) % 4;
    end
    i2c_master_model_inst.stop();
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("wrong value watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    rnd = 32'h5dfe;
    rst_b = 1'b0;
    addr_sel_hi_pin = 1'b0;
    addr_sel_lo_pin = 1'b0;
    load_update_n = 1'b1;
    foreach (in_m[i]) begin
      in_m[i] = DATA_RST;
      dac_m[i] = DATA_RST;
    end
    pd_m = PD_RST;
    mask_m = MASK_RST;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    check_all();
    for (int a = 0; a < 4; a++) begin
      {addr_sel_hi_pin, addr_sel_lo_pin} <= 2'(a);
      repeat (10) @(posedge clk);
      rnd = lfsr(rnd);
      frame(CMD_WR_UPD, rnd[19:16], rnd[15:0]);
    end
    for (int i = 0; i < 3; i++) begin
      i2c_master_model_inst.start();
      i2c_master_model_inst.xfer(i == 0 ? 8'h00 : i == 1 ? 8'hF0 : {ADDR_FIXED, 2'b10, 1'b0}, 1'b1, q, k);
      chk("nack", 64'h1, 64'(k));
      i2c_master_model_inst.stop();
    end
    check_all();
    $display("test addressing done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      frame(CMD_WR_IN, rnd[19:16] | 4'h1, rnd[15:0]);
    end
    frame(CMD_UPD_DAC, 4'b0101, 16'hFFFF);
    readback(4'b1111, 5);
    readback(4'b0100, 3);
    $display("test write update readback done");
    frame(CMD_MASK, 4'h0, 16'h0005);
    frame(CMD_WR_IN, 4'hF, 16'hA5C3);
    load_update_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int ch = 0; ch < NUM_CH; ch++) if (!mask_m[ch]) dac_m[ch] = in_m[ch];
    check_all();
    rnd = lfsr(rnd);
    frame(CMD_WR_IN, 4'hF, rnd[15:0]);
    load_update_n <= 1'b1;
    frame(CMD_MASK, 4'h0, 16'h0000);
    $display("test load pin done");
    frame(CMD_PWRDN, 4'h0, 16'h00E4);
    rnd = lfsr(rnd);
    frame(CMD_PWRDN, rnd[19:16], rnd[15:0]);
    frame(CMD_WR_UPD, 4'hF, rnd[31:16]);
    $display("test power-down done");
    for (int c = 0; c < 16; c++) if (c == 0 || c > 5) begin
      rnd = lfsr(rnd);
      frame(4'(c), 4'hF, rnd[15:0]);
    end
    $display("test reserved commands done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
